/* File: include/arb_pkg.sv */
// package with register map, field positions and mode codes of the arbiter
package arb_pkg;
  // register byte offsets on apb
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DATA = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFS_CFG = 8'h10;
  // control register fields
  localparam int B_MODE_HI = 7;
  localparam int B_MODE_LO = 6;
  localparam int B_LOST = 5;
  localparam int B_ACLK = 4;
  localparam int B_FIN = 3;
  localparam int B_RUN = 2;
  localparam int B_OVF = 1;
  localparam int B_MSB = 0;
  // config register fields
  localparam int B_SRC = 0;
  // interrupt status fields
  localparam int I_FIN = 0;
  localparam int I_OVF = 1;
  localparam int I_LOST = 2;
  localparam int IRQ_W = 3;
  // counter
  localparam int CNT_W = 9;
  localparam logic [8:0] CNT_MAX = 9'h1ff;
  localparam logic [8:0] CNT_ZERO = 9'h000;
  localparam logic [8:0] CNT_ONE = 9'h001;
  // arbitration sample points
  localparam logic [8:0] SAMPLE_BUS = 9'h038;
  localparam logic [8:0] SAMPLE_PRE = 9'h008;
  // bus clock divided by four
  localparam logic [1:0] BUS_DIV_LAST = 2'h3;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  typedef enum logic [1:0] {
    MODE_IDLE = 2'b00,
    MODE_MEAS = 2'b01,
    MODE_ARB = 2'b10,
    MODE_RSVD = 2'b11
  } arb_mode_t;
  typedef enum {ST_WAIT, ST_RUN, ST_DONE} meas_state_t;
endpackage

/* File: rtl/arb_sync.sv */
// three flip-flop input synchroniser with agreement filter
`timescale 1ns/1ns
module arb_sync (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // pin and filtered level
  input wire logic pin_in,
  output logic level_out
);
  logic [2:0] sh_r;
  logic [2:0] sh_nxt;
  logic lvl_r;
  logic lvl_nxt;

  always_comb begin
    sh_nxt = {sh_r[1:0], pin_in};
    lvl_nxt = lvl_r;
    if (sh_r[1] == sh_r[2]) begin
      lvl_nxt = sh_r[2];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sh_r <= 3'h7;
      lvl_r <= 1'b1;
    end else begin
      sh_r <= sh_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  assign level_out = lvl_r;
endmodule

/* File: rtl/serial_arbiter_counter.sv */
// serial bus arbiter with nine-bit bit-time counter and apb registers
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module serial_arbiter_counter
  import arb_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RESETN_IN,
  // apb slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // prescaler output ticks, one pulse per prescaler clock
  input wire logic PRESC_BUS_TICK_IN,
  input wire logic PRESC_OSC_TICK_IN,
  // serial line
  input wire logic RXD_IN,
  input wire logic TX_SHIFTER_OUTPUT_IN,
  output logic TXD_OUT,
  // interrupt
  output logic IRQ_OUT
);
  import arb_pkg::*;

  logic rx_lvl;
  logic [7:0] ctrl_wr_data;
  logic wr_en;
  logic rd_en;
  logic ctrl_wr;
  logic addr_ok;

  logic [1:0] mode_r, mode_nxt;
  logic aclk_r, aclk_nxt;
  logic src_r, src_nxt;
  logic lost_r, lost_nxt;
  logic fin_r, fin_nxt;
  logic ovf_r, ovf_nxt;
  logic [8:0] cnt_r, cnt_nxt;
  logic run_r, run_nxt;
  meas_state_t mst_r, mst_nxt;
  logic [1:0] div_r, div_nxt;
  logic half_r, half_nxt;
  logic rx_d_r, rx_d_nxt;
  logic tx_d_r, tx_d_nxt;
  logic sampled_r, sampled_nxt;
  logic [IRQ_W-1:0] ist_r, ist_nxt;
  logic [IRQ_W-1:0] imask_r, imask_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  logic tick;
  logic presc_tick;
  logic rx_fall;
  logic rx_rise;
  logic tx_rise;
  logic tx_fall;
  logic cnt_wrap;
  logic set_fin;
  logic set_lost;

  function automatic logic [7:0] ctrl_image(
    input logic [1:0] m, input logic lo, input logic ak,
    input logic fi, input logic rn, input logic ov, input logic msb);
    logic [7:0] v;
    v = 8'h00;
    v[B_MODE_HI] = m[1];
    v[B_MODE_LO] = m[0];
    v[B_LOST] = lo;
    v[B_ACLK] = ak;
    v[B_FIN] = fi;
    v[B_RUN] = rn;
    v[B_OVF] = ov;
    v[B_MSB] = msb;
    return v;
  endfunction

  arb_sync u_rx_sync (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RESETN_IN),
    .pin_in(RXD_IN),
    .level_out(rx_lvl)
  );

  // apb decode, zero wait states
  assign wr_en = PSEL_IN & PENABLE_IN & PWRITE_IN;
  assign rd_en = PSEL_IN & ~PENABLE_IN & ~PWRITE_IN;
  assign ctrl_wr = wr_en & (PADDR_IN == OFS_CTRL);
  assign ctrl_wr_data = PWDATA_IN[7:0];
  assign addr_ok = (PADDR_IN == OFS_CTRL) | (PADDR_IN == OFS_DATA) |
                   (PADDR_IN == OFS_IRQ_STAT) | (PADDR_IN == OFS_IRQ_MASK) |
                   (PADDR_IN == OFS_CFG);
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~addr_ok;
  assign PRDATA_OUT = rdata_r;

  // counter clock enables
  assign presc_tick = src_r ? PRESC_OSC_TICK_IN : PRESC_BUS_TICK_IN;
  assign tick = aclk_r ? (presc_tick & half_r)
                       : (div_r == BUS_DIV_LAST);

  assign rx_fall = rx_d_r & ~rx_lvl;
  assign rx_rise = ~rx_d_r & rx_lvl;
  assign tx_rise = ~tx_d_r & TX_SHIFTER_OUTPUT_IN;
  assign tx_fall = tx_d_r & ~TX_SHIFTER_OUTPUT_IN;
  assign cnt_wrap = run_r & tick & (cnt_r == CNT_MAX);

  always_comb begin
    mode_nxt = mode_r;
    aclk_nxt = aclk_r;
    src_nxt = src_r;
    imask_nxt = imask_r;
    div_nxt = div_r + 2'h1;
    half_nxt = presc_tick ? ~half_r : half_r;
    rx_d_nxt = rx_lvl;
    tx_d_nxt = TX_SHIFTER_OUTPUT_IN;
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    mst_nxt = mst_r;
    sampled_nxt = sampled_r;
    set_fin = 1'b0;
    set_lost = 1'b0;
    if (run_r && tick) begin
      cnt_nxt = cnt_r + CNT_ONE;
    end
    case (arb_mode_t'(mode_r))
      MODE_MEAS: begin
        case (mst_r)
          ST_WAIT: begin
            if (aclk_r ? !rx_lvl : rx_fall) begin
              run_nxt = 1'b1;
              mst_nxt = ST_RUN;
            end
          end
          ST_RUN: begin
            if (aclk_r ? rx_rise : rx_fall) begin
              run_nxt = 1'b0;
              set_fin = 1'b1;
              mst_nxt = ST_DONE;
            end
          end
          ST_DONE: run_nxt = 1'b0;
          default: mst_nxt = ST_WAIT;
        endcase
      end
      MODE_ARB: begin
        if (tx_rise && !lost_r) begin
          cnt_nxt = CNT_ZERO;
          run_nxt = 1'b1;
          sampled_nxt = 1'b0;
        end else if (tx_fall && !sampled_r) begin
          cnt_nxt = CNT_ZERO;
          run_nxt = 1'b0;
        end
        if (run_r && !sampled_r &&
            cnt_r == (aclk_r ? SAMPLE_PRE : SAMPLE_BUS)) begin
          sampled_nxt = 1'b1;
          if (!rx_lvl) begin
            set_lost = 1'b1;
            run_nxt = 1'b0;
          end
        end
      end
      default: begin
        cnt_nxt = CNT_ZERO;
        run_nxt = 1'b0;
        mst_nxt = ST_WAIT;
        sampled_nxt = 1'b0;
      end
    endcase
    fin_nxt = fin_r;
    ovf_nxt = ovf_r;
    lost_nxt = lost_r;
    if (ctrl_wr) begin
      mode_nxt = {ctrl_wr_data[B_MODE_HI], ctrl_wr_data[B_MODE_LO]};
      aclk_nxt = ctrl_wr_data[B_ACLK];
      cnt_nxt = CNT_ZERO;
      fin_nxt = 1'b0;
      ovf_nxt = 1'b0;
      mst_nxt = ST_WAIT;
      run_nxt = 1'b0;
      sampled_nxt = 1'b0;
      if (!ctrl_wr_data[B_MODE_HI]) begin
        lost_nxt = 1'b0;
      end
    end
    // hardware set wins over the clear
    if (set_fin) begin
      fin_nxt = 1'b1;
    end
    if (cnt_wrap) begin
      ovf_nxt = 1'b1;
    end
    if (set_lost) begin
      lost_nxt = 1'b1;
    end
    if (wr_en && PADDR_IN == OFS_CFG) begin
      src_nxt = PWDATA_IN[B_SRC];
    end
    if (wr_en && PADDR_IN == OFS_IRQ_MASK) begin
      imask_nxt = PWDATA_IN[IRQ_W-1:0];
    end
    ist_nxt = ist_r;
    if (wr_en && PADDR_IN == OFS_IRQ_STAT) begin
      ist_nxt = ist_r & ~PWDATA_IN[IRQ_W-1:0];
    end
    if (set_fin) begin
      ist_nxt[I_FIN] = 1'b1;
    end
    if (cnt_wrap) begin
      ist_nxt[I_OVF] = 1'b1;
    end
    if (set_lost) begin
      ist_nxt[I_LOST] = 1'b1;
    end
    rdata_nxt = rdata_r;
    if (rd_en) begin
      case (PADDR_IN)
        OFS_CTRL: rdata_nxt = {24'h000000, ctrl_image(mode_r, lost_r,
          aclk_r, fin_r, run_r, ovf_r, cnt_r[CNT_W-1])};
        OFS_DATA: rdata_nxt = {24'h000000, cnt_r[7:0]};
        OFS_IRQ_STAT: rdata_nxt = {29'h00000000, ist_r};
        OFS_IRQ_MASK: rdata_nxt = {29'h00000000, imask_r};
        OFS_CFG: rdata_nxt = {31'h00000000, src_r};
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      mode_r <= MODE_IDLE;
      aclk_r <= 1'b0;
      src_r <= 1'b0;
      lost_r <= 1'b0;
      fin_r <= 1'b0;
      ovf_r <= 1'b0;
      cnt_r <= CNT_ZERO;
      run_r <= 1'b0;
      mst_r <= ST_WAIT;
      div_r <= 2'h0;
      half_r <= 1'b0;
      rx_d_r <= 1'b1;
      tx_d_r <= 1'b1;
      sampled_r <= 1'b0;
      ist_r <= '0;
      imask_r <= '0;
      rdata_r <= 32'h00000000;
    end else begin
      mode_r <= mode_nxt;
      aclk_r <= aclk_nxt;
      src_r <= src_nxt;
      lost_r <= lost_nxt;
      fin_r <= fin_nxt;
      ovf_r <= ovf_nxt;
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
      mst_r <= mst_nxt;
      div_r <= div_nxt;
      half_r <= half_nxt;
      rx_d_r <= rx_d_nxt;
      tx_d_r <= tx_d_nxt;
      sampled_r <= sampled_nxt;
      ist_r <= ist_nxt;
      imask_r <= imask_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // transmit pin forced high while arbitration is lost
  assign TXD_OUT = TX_SHIFTER_OUTPUT_IN | lost_r;
  assign IRQ_OUT = |(ist_r & imask_r);
endmodule

/* File: bench/arb_monitor.sv */
// port checker for the serial arbiter
`timescale 1ns/1ns
module arb_monitor
  import arb_pkg::*;
(
  // clock, reset and apb
  input wire logic SYS_CLK_IN,
  input wire logic RESETN_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PSLVERR_OUT,
  // serial and interrupt
  input wire logic TX_SHIFTER_OUTPUT_IN,
  input wire logic TXD_OUT,
  input wire logic IRQ_OUT
);
  logic [1:0] mode_r;
  logic [2:0] mask_r;
  logic wr;
  logic rc;
  assign wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
  assign rc = PSEL_IN && PENABLE_IN && !PWRITE_IN;
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      mode_r <= 2'h0;
      mask_r <= 3'h0;
    end else if (wr && PADDR_IN == OFS_CTRL) begin
      mode_r <= PWDATA_IN[7:6];
    end else if (wr && PADDR_IN == OFS_IRQ_MASK) begin
      mask_r <= PWDATA_IN[2:0];
    end
  end
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  a_mode_read: assert property (rc && PADDR_IN == OFS_CTRL
    |-> PRDATA_OUT[7:6] == mode_r) else $error("mode bits wrong");
  a_idle_flags: assert property (rc && PADDR_IN == OFS_CTRL
    && mode_r == 2'h0 |-> PRDATA_OUT[3:0] == 4'h0) else $error("idle flags");
  a_idle_data: assert property (rc && PADDR_IN == OFS_DATA
    && mode_r == 2'h0 |-> PRDATA_OUT == 32'h0) else $error("idle count");
  a_lost_clear: assert property (rc && PADDR_IN == OFS_CTRL
    && !mode_r[1] |-> !PRDATA_OUT[B_LOST]) else $error("lost kept");
  a_txd_pass: assert property (TX_SHIFTER_OUTPUT_IN |-> TXD_OUT)
    else $error("txd low");
  a_txd_forced: assert property (TXD_OUT && !TX_SHIFTER_OUTPUT_IN
    |-> mode_r[1]) else $error("txd forced");
  a_irq_masked: assert property (mask_r == 3'h0 && $past(mask_r) == 3'h0
    |-> !IRQ_OUT) else $error("irq unmasked");
  a_slverr_unmapped: assert property (PSEL_IN && PENABLE_IN
    && PADDR_IN > OFS_CFG |-> PSLVERR_OUT) else $error("no slverr");
  c_fin: cover property (rc && PADDR_IN == OFS_CTRL && PRDATA_OUT[B_FIN]);
  c_forced: cover property (TXD_OUT && !TX_SHIFTER_OUTPUT_IN);
  c_irq: cover property (IRQ_OUT);
endmodule
bind serial_arbiter_counter arb_monitor u_arb_monitor (.SYS_CLK_IN,
  .RESETN_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN, .PADDR_IN, .PWDATA_IN,
  .PRDATA_OUT, .PSLVERR_OUT, .TX_SHIFTER_OUTPUT_IN, .TXD_OUT, .IRQ_OUT);

/* File: bench/bus_node_model.sv */
// other node on the shared wired-and serial line
`timescale 1ns/1ns
module bus_node_model (
  // our transmit pin and the other node's dominant request
  input wire logic txd_in,
  input wire logic dominant_in,
  // line level at the receive pin
  output logic line_out
);
  // pull-up keeps the line high unless a node drives it low
  assign line_out = txd_in && !dominant_in;
endmodule

/* File: bench/serial_arbiter_counter_bench.sv */
// self-checking bench for the serial arbiter counter
`timescale 1ns/1ns
module serial_arbiter_counter_bench;
  import arb_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic shift = 1'b1;
  logic dom = 1'b0;
  logic [2:0] tcnt = 3'h0;
  logic [31:0] prdata;
  logic [31:0] rv;
  logic pready, pslverr, txd, irq, rxd, err_seen;
  int num_errors = 0;
  int n_compared = 0;
  always #20 clk = ~clk;
  // oscillator tick every 2 cycles, bus tick every 6
  always @(posedge clk) tcnt <= (tcnt == 3'h5) ? 3'h0 : tcnt + 3'h1;
  serial_arbiter_counter u_serial_arbiter_counter (.SYS_CLK_IN(clk),
    .RESETN_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .PRESC_BUS_TICK_IN(tcnt == 3'h0), .PRESC_OSC_TICK_IN(tcnt[0]),
    .RXD_IN(rxd), .TX_SHIFTER_OUTPUT_IN(shift), .TXD_OUT(txd),
    .IRQ_OUT(irq));
  bus_node_model u_bus_node_model (.txd_in(txd), .dominant_in(dom),
    .line_out(rxd));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rv = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [31:0] lo,
      input logic [31:0] hi, input logic [31:0] g);
    n_compared++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      num_errors++;
      $display("BAD %s exp %h..%h got %h", n, lo, hi, g);
    end
  endtask
  task automatic t_reset;
    apb(0, OFS_CTRL, 0);
    chk("ctrl", 0, 0, rv);
    apb(0, OFS_DATA, 0);
    chk("data", 0, 0, rv);
    chk("irq", 0, 0, irq);
    apb(0, 8'h20, 0);
    chk("slverr", 1, 1, err_seen);
    chk("unmapped", 0, 0, rv);
    apb(1, OFS_CTRL, 32'hc0);
    apb(0, OFS_CTRL, 0);
    chk("mode", 3, 3, rv[7:6]);
    apb(1, OFS_CTRL, 0);
    $display("test reset done");
  endtask
  task automatic t_meas_bus;
    apb(1, OFS_CTRL, 32'h40);
    dom <= 1'b1;
    cyc(20);
    dom <= 1'b0;
    cyc(200);
    apb(0, OFS_CTRL, 0);
    chk("run", 1, 1, rv[B_RUN]);
    chk("mode", 1, 1, rv[7:6]);
    cyc(177);
    dom <= 1'b1;
    cyc(20);
    dom <= 1'b0;
    cyc(10);
    apb(0, OFS_DATA, 0);
    chk("count", 32'h63, 32'h65, rv);
    apb(0, OFS_CTRL, 0);
    chk("fin", 1, 1, rv[B_FIN]);
    chk("run", 0, 0, rv[B_RUN]);
    chk("irq", 0, 0, irq);
    apb(1, OFS_IRQ_MASK, 32'h1);
    cyc(1);
    chk("irq", 1, 1, irq);
    apb(1, OFS_IRQ_STAT, 32'h1);
    cyc(1);
    chk("irq", 0, 0, irq);
    apb(1, OFS_CTRL, 32'h40);
    apb(0, OFS_CTRL, 0);
    chk("fin", 0, 0, rv[B_FIN]);
    apb(0, OFS_DATA, 0);
    chk("count", 0, 0, rv);
    apb(1, OFS_CTRL, 0);
    $display("test bus measure done");
  endtask
  task automatic t_meas_pre;
    apb(1, OFS_CFG, 1);
    dom <= 1'b1;
    cyc(10);
    apb(1, OFS_CTRL, 32'h50);
    cyc(197);
    dom <= 1'b0;
    cyc(10);
    apb(0, OFS_DATA, 0);
    chk("count", 32'h30, 32'h34, rv);
    apb(0, OFS_CTRL, 0);
    chk("run", 0, 0, rv[B_RUN]);
    apb(1, OFS_CTRL, 0);
    $display("test prescaler measure done");
  endtask
  task automatic t_overflow;
    dom <= 1'b1;
    cyc(10);
    apb(1, OFS_CTRL, 32'h50);
    cyc(1200);
    apb(0, OFS_CTRL, 0);
    chk("msb", 1, 1, rv[B_MSB]);
    cyc(1000);
    dom <= 1'b0;
    cyc(10);
    apb(0, OFS_CTRL, 0);
    chk("ovf", 1, 1, rv[B_OVF]);
    chk("msb", 0, 0, rv[B_MSB]);
    apb(0, OFS_DATA, 0);
    chk("count", 32'h24, 32'h2a, rv);
    apb(1, OFS_CTRL, 32'h50);
    apb(0, OFS_CTRL, 0);
    chk("ovf", 0, 0, rv[B_OVF]);
    apb(1, OFS_CTRL, 0);
    $display("test overflow done");
  endtask
  task automatic t_arb;
    apb(1, OFS_CFG, 0);
    apb(1, OFS_CTRL, 32'h80);
    shift <= 1'b0;
    cyc(4);
    shift <= 1'b1;
    cyc(300);
    apb(0, OFS_CTRL, 0);
    chk("lost", 0, 0, rv[B_LOST]);
    chk("mode", 2, 2, rv[7:6]);
    shift <= 1'b0;
    cyc(4);
    shift <= 1'b1;
    dom <= 1'b1;
    cyc(300);
    apb(0, OFS_CTRL, 0);
    chk("lost", 1, 1, rv[B_LOST]);
    // finish, overflow and lost events have all been latched by now
    apb(0, OFS_IRQ_STAT, 0);
    chk("status", 32'h7, 32'h7, rv);
    apb(1, OFS_IRQ_STAT, 32'h7);
    apb(0, OFS_IRQ_STAT, 0);
    chk("status clear", 0, 0, rv);
    chk("irq", 0, 0, irq);
    shift <= 1'b0;
    cyc(2);
    chk("txd", 1, 1, txd);
    apb(1, OFS_CTRL, 32'h80);
    apb(0, OFS_CTRL, 0);
    chk("lost", 1, 1, rv[B_LOST]);
    apb(1, OFS_CTRL, 0);
    cyc(1);
    chk("txd", 0, 0, txd);
    apb(0, OFS_CTRL, 0);
    chk("lost cleared", 0, 0, rv[B_LOST]);
    dom <= 1'b0;
    shift <= 1'b1;
    $display("test arbitration done");
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #400000;
    num_errors++;
    complete_run;
  end
  initial begin
    cyc(8);
    rst_n <= 1'b1;
    t_reset;
    t_meas_bus;
    t_meas_pre;
    t_overflow;
    t_arb;
    complete_run;
  end
endmodule
